// [hdl/rx_status_pkg.sv]
// Constants, register map and state type of the serial receive status block
package rx_status_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [13:0] IDX_STAT1 = 14'h3084;
  localparam logic [13:0] IDX_STAT2 = 14'h3085;
  localparam logic [13:0] IDX_DATA  = 14'h3087;
  localparam logic [13:0] IDX_CTRL  = 14'h3088;
  localparam logic [13:0] IDX_ISTAT = 14'h3089;
  localparam logic [13:0] IDX_IMASK = 14'h308a;
  localparam int          LANE_LOW  = 0;
  localparam int          DIV_LANE  = 1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Status one bit positions
  localparam int S1_PF   = 0;
  localparam int S1_FE   = 1;
  localparam int S1_NF   = 2;
  localparam int S1_RX_FULL_FLAG = 5;
  // Status two bit positions
  localparam int S2_BRK   = 7;
  localparam int S2_EDGE  = 6;
  localparam int S2_RSV   = 5;
  localparam int S2_INV   = 4;
  localparam int S2_RWUID = 3;
  localparam int S2_BRK13 = 2;
  localparam int S2_LONG_BREAK_ENABLE = 1;
  // Control register: parity enable, odd parity, nine bits, two stops, divisor
  localparam int         C_PE     = 0;
  localparam int         C_PODD   = 1;
  localparam int         C_M9     = 2;
  localparam int         C_TWO_STOP_SELECT   = 3;
  localparam int         DIV_LSB  = 8;
  localparam logic [7:0] CTRL_MASK = 8'h0f;
  // Interrupt status and mask bits
  localparam int IRQ_N      = 6;
  localparam int IRQ_RX     = 0;
  localparam int IRQ_NOISE  = 1;
  localparam int IRQ_FRAME  = 2;
  localparam int IRQ_PARITY = 3;
  localparam int IRQ_BREAK  = 4;
  localparam int IRQ_EDGE   = 5;
  // Bit timing: sixteen ticks per bit and the sample windows
  localparam int          CLOCK_HZ     = 25_000_000;
  localparam int          BAUD_DEFAULT = 9600;
  localparam int          OSR          = 16;
  localparam logic [7:0]  DIV_RST      = 8'(CLOCK_HZ / (OSR * BAUD_DEFAULT) - 1);
  localparam logic [3:0]  BIT_END      = 4'hf;
  localparam logic [3:0]  START_FIRST  = 4'h2;
  localparam logic [3:0]  START_LAST   = 4'h8;
  localparam logic [3:0]  DATA_FIRST   = 4'h7;
  localparam logic [3:0]  DATA_LAST    = 4'h9;
  localparam logic [2:0]  START_MAJ    = 3'h4;
  localparam logic [2:0]  DATA_MAJ     = 3'h2;
  localparam logic [2:0]  DATA_N       = 3'h3;
  localparam logic [3:0]  LAST_DATA8   = 4'h7;
  localparam logic [3:0]  LAST_DATA9   = 4'h8;
  localparam logic [3:0]  BRK_BASE     = 4'ha;
  localparam logic [3:0]  TICK_PAD     = 4'h0;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h3,
    RX_STOP  = 2'h2
  } rx_state_type;

  typedef struct packed {
    rx_state_type rx_state;
    logic [7:0]   presc;
    logic [3:0]   sub;
    logic [2:0]   ones;
    logic [3:0]   bitn;
    logic [8:0]   shift;
    logic         noise;
    logic         ferr;
    logic         rxd_prev;
    logic [7:0]   brk_cnt;
    logic [5:0]   s1f;
    logic [5:0]   arm;
    logic [8:0]   data;
    logic         break_detect_flag;
    logic         rx_edge_flag;
    logic         rx_invert;
    logic         rwuid;
    logic         brk13;
    logic         long_break_enable;
    logic [7:0]   ctrl;
    logic [7:0]   div;
    logic [5:0]   ist;
    logic [5:0]   imsk;
    logic         aw_have;
    logic [13:0]  aw_idx;
    logic         w_have;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } state_type;

  localparam state_type STATE_RST = '{rx_state: RX_IDLE, div: DIV_RST, default: '0};
endpackage

// [hdl/serial_rx_status_flags.sv]
// Receive status flags of an asynchronous serial port behind an AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
module serial_rx_status_flags
  import rx_status_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        rx_pin,
  output logic             irq,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [15:0] awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [15:0] araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);

  state_type   r;
  state_type   n;
  logic        rxd;
  logic        tick;
  logic        edge_ev;
  logic        bit_end;
  logic        done_ev;
  logic        ferr_ev;
  logic        perr_ev;
  logic        noise_ev;
  logic        brk_hit;
  logic        wr_ev;
  logic        rd_ev;
  logic        rd_dat_ev;
  logic [13:0] rd_idx;
  logic [3:0]  brk_bits;
  logic [7:0]  brk_lim;
  logic [3:0]  last_data;
  logic [8:0]  char_w;
  logic [7:0]  s2_val;

  //////////////////////////////////////////////////////////////////////////////
  // Majority and disagreement of three bit samples
  function automatic logic maj3(input logic [2:0] ones);
    return ones >= DATA_MAJ;
  endfunction

  function automatic logic noisy3(input logic [2:0] ones);
    return (ones != 3'h0) && (ones != DATA_N);
  endfunction

  // Index decode shared by reads and writes
  function automatic logic mapped(input logic [13:0] idx);
    return idx inside {IDX_STAT1, IDX_STAT2, IDX_DATA, IDX_CTRL, IDX_ISTAT, IDX_IMASK};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshakes are combinational from the held state
  assign awready   = !r.aw_have && !r.bvalid;
  assign wready    = !r.w_have && !r.bvalid;
  assign arready   = !r.rvalid;
  assign bvalid    = r.bvalid;
  assign bresp     = r.bresp;
  assign rvalid    = r.rvalid;
  assign rdata     = r.rdata;
  assign rresp     = r.rresp;
  assign irq       = |(r.ist & r.imsk);
  assign wr_ev     = r.aw_have && r.w_have;
  assign rd_ev     = arvalid && !r.rvalid;
  assign rd_idx    = araddr[15:2];
  assign rd_dat_ev = rd_ev && (rd_idx == IDX_DATA);

  // Line level after optional inversion; edges are judged on this
  assign rxd     = rx_pin ^ r.rx_invert;
  assign edge_ev = r.rxd_prev && !rxd;
  assign tick    = r.presc >= r.div;
  assign bit_end = tick && (r.sub == BIT_END);

  // break length from width, stop bits and enable
  assign brk_bits = BRK_BASE + {3'h0, r.ctrl[C_M9]} + {3'h0, r.ctrl[C_TWO_STOP_SELECT]} + {3'h0, r.long_break_enable};
  assign brk_lim  = {brk_bits, TICK_PAD};
  assign brk_hit  = tick && !rxd && (r.brk_cnt == brk_lim - 8'h1);

  // Frame completion terms, valid at the last stop bit end
  assign last_data = r.ctrl[C_M9] ? LAST_DATA9 : LAST_DATA8;
  assign char_w    = r.ctrl[C_M9] ? r.shift : {1'b0, r.shift[8:1]};
  assign done_ev   = (r.rx_state == RX_STOP) && bit_end && (r.bitn == {3'h0, r.ctrl[C_TWO_STOP_SELECT]});
  assign ferr_ev   = r.ferr || !maj3(r.ones);
  assign noise_ev  = r.noise || noisy3(r.ones);
  assign perr_ev   = r.ctrl[C_PE] && ((^char_w) != r.ctrl[C_PODD]);

  // reserved bit packed as a constant zero
  assign s2_val = {r.break_detect_flag, r.rx_edge_flag, 1'b0, r.rx_invert,
                   r.rwuid, r.brk13, r.long_break_enable, r.rx_state != RX_IDLE};

  //////////////////////////////////////////////////////////////////////////////
  // Next state; clears come first so that a same-cycle set wins
  always_comb begin
    n          = r;
    n.presc    = tick ? 8'h0 : r.presc + 8'h1;
    n.rxd_prev = rxd;
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (awvalid && awready) begin
      n.aw_have = 1'b1;
      n.aw_idx  = awaddr[15:2];
    end
    if (wvalid && wready) begin
      n.w_have = 1'b1;
      n.wdata  = wdata;
      n.wstrb  = wstrb;
    end
    // Register write once address and data are both held
    if (wr_ev) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = mapped(r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
      if (r.wstrb[LANE_LOW]) begin
        case (r.aw_idx)
          IDX_STAT2: begin
            if (r.wdata[S2_BRK]) begin
              n.break_detect_flag = 1'b0;
            end
            if (r.wdata[S2_EDGE]) begin
              n.rx_edge_flag = 1'b0;
            end
            n.rx_invert         = r.wdata[S2_INV];
            n.rwuid             = r.wdata[S2_RWUID];
            n.brk13             = r.wdata[S2_BRK13];
            n.long_break_enable = r.wdata[S2_LONG_BREAK_ENABLE];
          end
          IDX_CTRL:  n.ctrl = r.wdata[7:0] & CTRL_MASK;
          IDX_ISTAT: n.ist = r.ist & ~r.wdata[IRQ_N-1:0];
          IDX_IMASK: n.imsk = r.wdata[IRQ_N-1:0];
          default: ;
        endcase
      end
      if (r.wstrb[DIV_LANE] && (r.aw_idx == IDX_CTRL)) begin
        n.div = r.wdata[DIV_LSB +: 8];
      end
    end
    // Register read with its side effects
    if (rd_ev) begin
      n.rvalid = 1'b1;
      n.rresp  = mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      n.rdata  = 32'h0;
      case (rd_idx)
        IDX_STAT1: begin
          n.rdata = 32'(r.s1f);
          n.arm   = r.s1f;
        end
        IDX_STAT2: n.rdata = 32'(s2_val);
        IDX_DATA: begin
          // flags armed by status read clear here
          n.rdata = 32'(r.data);
          n.s1f   = r.s1f & ~r.arm;
          n.arm   = 6'h0;
        end
        IDX_CTRL:  n.rdata = 32'({r.div, r.ctrl});
        IDX_ISTAT: n.rdata = 32'(r.ist);
        IDX_IMASK: n.rdata = 32'(r.imsk);
        default: ;
      endcase
    end
    if (edge_ev) begin
      n.rx_edge_flag   = 1'b1;
      n.ist[IRQ_EDGE]  = 1'b1;
    end
    // low-time counter saturates at the threshold
    if (rxd) begin
      n.brk_cnt = 8'h0;
    end else if (tick && (r.brk_cnt != brk_lim)) begin
      n.brk_cnt = r.brk_cnt + 8'h1;
    end
    // break recognised only with detection on
    if (brk_hit && r.long_break_enable) begin
      n.break_detect_flag = 1'b1;
      n.ist[IRQ_BREAK]    = 1'b1;
    end
    // receiver sampling: seven in start, three in later bits
    unique case (r.rx_state)
      RX_IDLE: begin
        if (edge_ev) begin
          n.rx_state = RX_START;
          n.presc    = 8'h0;
          n.sub      = 4'h0;
          n.ones     = 3'h0;
          n.bitn     = 4'h0;
          n.noise    = 1'b0;
          n.ferr     = 1'b0;
        end
      end
      RX_START: begin
        if (tick) begin
          n.sub = r.sub + 4'h1;
          if (r.sub >= START_FIRST && r.sub <= START_LAST) begin
            n.ones = r.ones + {2'h0, rxd};
          end
          if (r.sub == BIT_END) begin
            n.ones = 3'h0;
            // A mostly high start bit is a glitch, not a frame
            if (r.ones >= START_MAJ) begin
              n.rx_state = RX_IDLE;
            end else begin
              n.rx_state = RX_DATA;
              n.noise    = r.ones != 3'h0;
            end
          end
        end
      end
      RX_DATA, RX_STOP: begin
        if (tick) begin
          n.sub = r.sub + 4'h1;
          if (r.sub >= DATA_FIRST && r.sub <= DATA_LAST) begin
            n.ones = r.ones + {2'h0, rxd};
          end
          if (r.sub == BIT_END) begin
            n.ones  = 3'h0;
            n.noise = noise_ev;
            n.bitn  = r.bitn + 4'h1;
            if (r.rx_state == RX_DATA) begin
              n.shift = {maj3(r.ones), r.shift[8:1]};
              if (r.bitn == last_data) begin
                n.rx_state = RX_STOP;
                n.bitn     = 4'h0;
              end
            end else begin
              // low stop sample marks a framing error
              n.ferr = ferr_ev;
              if (done_ev) begin
                n.rx_state = RX_IDLE;
              end
            end
          end
        end
      end
    endcase
    // break detect mode posts nothing for a character
    if (done_ev && !r.long_break_enable) begin
      n.data          = char_w;
      n.s1f[S1_RX_FULL_FLAG]  = 1'b1;
      n.ist[IRQ_RX]   = 1'b1;
      if (ferr_ev) begin
        n.s1f[S1_FE]     = 1'b1;
        n.ist[IRQ_FRAME] = 1'b1;
      end
      if (perr_ev) begin
        n.s1f[S1_PF]      = 1'b1;
        n.ist[IRQ_PARITY] = 1'b1;
      end
      if (noise_ev) begin
        n.s1f[S1_NF]     = 1'b1;
        n.ist[IRQ_NOISE] = 1'b1;
      end
    end
  end

  // reset clears every flag and status two
  always_ff @(posedge clock) begin
    if (srst) begin
      r <= STATE_RST;
    end else begin
      r <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the flag behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  property p_fe_with_full;
    done_ev && !r.long_break_enable && ferr_ev |=> r.s1f[S1_FE] && r.s1f[S1_RX_FULL_FLAG];
  endproperty
  a_fe_with_full: assert property (p_fe_with_full) else $error("framing flag missing");

  // framing flag falls only on an armed data read
  property p_fe_clear;
    $fell(r.s1f[S1_FE]) |-> $past(rd_dat_ev) && $past(r.arm[S1_FE]);
  endproperty
  a_fe_clear: assert property (p_fe_clear) else $error("framing flag cleared wrongly");

  property p_pf_with_full;
    done_ev && !r.long_break_enable && perr_ev |=> r.s1f[S1_PF] && r.s1f[S1_RX_FULL_FLAG];
  endproperty
  a_pf_with_full: assert property (p_pf_with_full) else $error("parity flag missing");

  sequence s_brk_seen;
    brk_hit && r.long_break_enable;
  endsequence
  property p_brk_set;
    s_brk_seen |=> r.break_detect_flag;
  endproperty
  a_brk_set: assert property (p_brk_set) else $error("break flag not set");

  // write-one clear of the break flag
  sequence s_brk_w1c;
    wr_ev && (r.aw_idx == IDX_STAT2) && r.wstrb[LANE_LOW] && r.wdata[S2_BRK] && !brk_hit;
  endsequence
  property p_brk_clear;
    s_brk_w1c |=> !r.break_detect_flag && r.bvalid;
  endproperty
  a_brk_clear: assert property (p_brk_clear) else $error("break flag not cleared");

  // edge flag follows an active edge
  property p_edge_set;
    edge_ev |=> r.rx_edge_flag && r.ist[IRQ_EDGE];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag not set");

  property p_rsv_zero;
    rd_ev && (rd_idx == IDX_STAT2) |=> r.rvalid && !r.rdata[S2_RSV] && r.rdata[S2_BRK] == $past(r.break_detect_flag);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit not zero");

  // rx full never rises in break detect mode
  property p_no_full_in_brk;
    $rose(r.s1f[S1_RX_FULL_FLAG]) |-> !$past(r.long_break_enable);
  endproperty
  a_no_full_in_brk: assert property (p_no_full_in_brk) else $error("rx full set in break mode");

endmodule

// [test/serial_node_model.sv]
// Remote serial node that drives the receive line with frames, breaks and glitches
`timescale 1ns/10ps
module serial_node_model (
  input  wire logic clock,
  output logic      line
);
  // Sixteen clocks per bit while the divisor is zero
  localparam int BIT_CLKS = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // Line idles high, as a pulled-up bus does
  initial begin
    line = 1'h1;
  end

  // Hold one level for a number of clocks; called just after a rising edge
  task automatic hold(input logic lvl, input int clks);
    line <= lvl;
    repeat (clks) @(posedge clock);
  endtask

  // One character: start, data low bit first, chosen stop level, then idle
  // stop bit level
  task automatic frame(input logic [8:0] d, input int nbits, input logic stop, input logic noisy);
    hold(1'h0, BIT_CLKS);
    for (int i = 0; i < nbits; i++) begin
      if (noisy && i == 1) begin
        hold(d[i], 9);
        hold(!d[i], 1);
        hold(d[i], 6);
      end else begin
        hold(d[i], BIT_CLKS);
      end
    end
    hold(stop, BIT_CLKS);
    hold(1'h1, 3 * BIT_CLKS);
  endtask
endmodule

// [test/serial_rx_status_flags_test.sv]
// Self-checking bench for the serial receive status flags block
`timescale 1ns/10ps
module serial_rx_status_flags_test
  import rx_status_pkg::*;
;
  logic        clock, srst, rx_pin, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          err_count, compares;
  // Parity cases: control, character, expected status one
  logic [7:0]  pctl [5] = '{8'h01, 8'h01, 8'h03, 8'h03, 8'h00};
  logic [7:0]  pbyte [5] = '{8'h03, 8'h01, 8'h01, 8'h03, 8'h01};
  logic [7:0]  pexp [5] = '{8'h20, 8'h21, 8'h20, 8'h21, 8'h20};
  // Break cases: control and threshold in bit times
  logic [7:0]  bctl [3] = '{8'h00, 8'h04, 8'h0c};
  int          blen [3] = '{11, 12, 13};

  ////////////////////////////////////////////////////////////////////////////////
  // Design and the remote node on its receive pin
  serial_rx_status_flags uut (
    .clock, .srst, .rx_pin, .irq, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp
  );
  serial_node_model node (.clock, .line(rx_pin));

  // 25 MHz clock
  initial begin
    clock = 1'h0;
    forever #20 clock = !clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Value compare; four-state so an unknown never matches
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write: both channels offered together, each dropped when taken
  task automatic wr(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    awaddr  <= {idx, 2'h0};
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    // Only the watchdog ends a wait, so a silent slave can never pass
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  // Read and compare the masked word and the response
  task automatic rd(input string what, input logic [13:0] idx, input logic [31:0] exp,
                    input logic [31:0] msk = 32'hffff_ffff, input logic [1:0] er = RESP_OKAY);
    @(posedge clock);
    araddr  <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk(what, exp, rdata & msk);
    chk("rresp", 32'(er), 32'(rresp));
  endtask

  // Level output looked at away from the clock edge
  task automatic chk_irq(input logic e);
    @(negedge clock);
    chk("irq", 32'(e), 32'(irq));
  endtask

  // Status one then data read empties the receive side
  task automatic drain;
    rd("status one", IDX_STAT1, 32'h0, 32'h0);
    rd("data", IDX_DATA, 32'h0, 32'h0);
  endtask

  task automatic results;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog; the tests need roughly a tenth of this span
  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    results;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    srst = 1'h1;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    awaddr = 16'h0;
    araddr = 16'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    err_count = 0;
    compares = 0;
    repeat (4) @(posedge clock);
    srst <= 1'h0;
    wr(IDX_CTRL, 32'h0, RESP_OKAY);
    rd("status two", IDX_STAT2, 32'h0);
    rd("status one", IDX_STAT1, 32'h0);
    wr(IDX_STAT2, 32'h20, RESP_OKAY);
    rd("status two", IDX_STAT2, 32'h0);
    // Short low pulse: an active edge that aborts as a start bit
    node.hold(1'h0, 4);
    node.hold(1'h1, 48);
    rd("edge flag", IDX_STAT2, 32'h40, 32'h40);
    wr(IDX_STAT2, 32'h0, RESP_OKAY);
    rd("edge flag", IDX_STAT2, 32'h40, 32'h40);
    // Interrupt raised, masked and cleared
    rd("irq status", IDX_ISTAT, 32'h20, 32'h20);
    chk_irq(1'h0);
    wr(IDX_IMASK, 32'h20, RESP_OKAY);
    chk_irq(1'h1);
    wr(IDX_IMASK, 32'h0, RESP_OKAY);
    chk_irq(1'h0);
    wr(IDX_IMASK, 32'h20, RESP_OKAY);
    wr(IDX_ISTAT, 32'h20, RESP_OKAY);
    chk_irq(1'h0);
    wr(IDX_STAT2, 32'h40, RESP_OKAY);
    rd("edge flag", IDX_STAT2, 32'h0, 32'h40);
    // Clean, misframed and noisy characters
    node.frame(9'h0a5, 8, 1'h1, 1'h0);
    rd("status one", IDX_STAT1, 32'h20);
    rd("data", IDX_DATA, 32'ha5, 32'hff);
    node.frame(9'h05a, 8, 1'h0, 1'h0);
    rd("data", IDX_DATA, 32'h5a, 32'hff);
    rd("status one", IDX_STAT1, 32'h22);
    rd("data", IDX_DATA, 32'h5a, 32'hff);
    rd("status one", IDX_STAT1, 32'h0);
    node.frame(9'h033, 8, 1'h1, 1'h1);
    rd("status one", IDX_STAT1, 32'h24);
    drain;
    // Parity on and off, even and odd
    for (int i = 0; i < 5; i++) begin
      wr(IDX_CTRL, {24'h0, pctl[i]}, RESP_OKAY);
      node.frame({1'h0, pbyte[i]}, 8, 1'h1, 1'h0);
      rd("status one", IDX_STAT1, {24'h0, pexp[i]});
      rd("data", IDX_DATA, 32'h0, 32'h0);
      rd("status one", IDX_STAT1, 32'h0);
    end
    // Long low with break detection off sets no break flag
    wr(IDX_CTRL, 32'h0, RESP_OKAY);
    node.hold(1'h0, 200);
    node.hold(1'h1, 48);
    rd("break flag", IDX_STAT2, 32'h0, 32'h80);
    drain;
    // All-zero character with misplaced stop while detection is on
    wr(IDX_STAT2, 32'h2, RESP_OKAY);
    node.frame(9'h0, 8, 1'h0, 1'h0);
    rd("break flag", IDX_STAT2, 32'h0, 32'h80);
    rd("status one", IDX_STAT1, 32'h0);
    // Threshold just missed, then just met, for three of the four frame shapes
    for (int i = 0; i < 3; i++) begin
      wr(IDX_CTRL, {24'h0, bctl[i]}, RESP_OKAY);
      node.hold(1'h0, blen[i] * 16 - 8);
      node.hold(1'h1, 48);
      rd("break flag", IDX_STAT2, 32'h0, 32'h80);
      node.hold(1'h0, blen[i] * 16 + 8);
      node.hold(1'h1, 48);
      rd("break flag", IDX_STAT2, 32'h80, 32'h80);
      rd("status one", IDX_STAT1, 32'h0);
      wr(IDX_STAT2, 32'h2, RESP_OKAY);
      rd("break flag", IDX_STAT2, 32'h80, 32'h80);
      wr(IDX_STAT2, 32'h82, RESP_OKAY);
      rd("break flag", IDX_STAT2, 32'h0, 32'h80);
    end
    // Unmapped place and a read-only register
    wr(IDX_STAT2, 32'h0, RESP_OKAY);
    rd("unmapped", 14'h3086, 32'h0, 32'hffff_ffff, RESP_SLVERR);
    wr(14'h3086, 32'hff, RESP_SLVERR);
    wr(IDX_STAT1, 32'hff, RESP_OKAY);
    rd("status one", IDX_STAT1, 32'h0);
    // Inverted line: only a rising pin edge counts
    wr(IDX_STAT2, 32'h10, RESP_OKAY);
    node.hold(1'h1, 240);
    drain;
    wr(IDX_STAT2, 32'h50, RESP_OKAY);
    node.hold(1'h0, 48);
    rd("edge flag", IDX_STAT2, 32'h0, 32'h40);
    node.hold(1'h1, 4);
    node.hold(1'h0, 48);
    rd("edge flag", IDX_STAT2, 32'h40, 32'h40);
    results;
  end
endmodule
